/* core/asr_pkg.sv */
// shared constants and types of the angle sensor readout die
// assumes a 10 MHz ref_clk_i; all pins are sampled by that clock
package asr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned ANGLE_REFRESH_PERIOD_US = 25;
    localparam int unsigned BASE_CYCLES = ANGLE_REFRESH_PERIOD_US * CYC_PER_US;
    localparam int unsigned POWER_ON_TIME_US = 300;
    localparam int unsigned POWER_ON_CYCLES = POWER_ON_TIME_US * CYC_PER_US;
    localparam int unsigned WDOG_CYCLES = 2 * BASE_CYCLES;
    localparam logic [7:0] BASE_LAST = 8'(BASE_CYCLES - 1);
    localparam logic [11:0] POR_LAST = 12'(POWER_ON_CYCLES - 1);
    localparam logic [8:0] WDOG_LAST = 9'(WDOG_CYCLES - 1);

    // ------------------------------------------------------------
    // angle code
    // ------------------------------------------------------------
    localparam int unsigned ANGLE_CODE_WIDTH = 13;
    localparam logic [12:0] HALF_TURN = 13'h1000;

    // ------------------------------------------------------------
    // local register port (byte offsets)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_NV_CFG = 4'h0;
    localparam logic [3:0] REG_NV_REF = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_ANGLE = 4'hC;
    localparam int unsigned NV_COPY_W = 4;
    localparam int unsigned NV_REF_PAR_BIT = 13;
    localparam logic [11:0] NV_CFG_RST = 12'h000;
    localparam logic [13:0] NV_REF_RST = 14'h0000;

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam int unsigned CMD_WRITE_BIT = 15;
    localparam logic [6:0] SPI_ADDR_ANGLE = 7'h00;
    localparam logic [6:0] SPI_ADDR_FLAGS = 7'h01;
    localparam logic [6:0] SPI_ADDR_CTRL = 7'h02;
    localparam int unsigned CTRL_MODE_BIT = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic low_speed;
        logic [2:0] averaging_exponent;
    } asr_mode_t;

    typedef struct packed {
        logic power_loss_flag;
        logic ecc_corrected_flag;
        logic ecc_detected_flag;
        logic missing_magnet_flag;
        logic internal_error_flag;
    } asr_flags_t;

    localparam asr_flags_t FLAGS_RST = 5'h00;

endpackage

/* core/asr_nv_store.sv */
// nonvolatile configuration image with voting and parity check
// assumes nv_rst_n_i comes from logic on ref_clk_i; power-up reset does not touch it
`timescale 1ns/1ps
module asr_nv_store
    import asr_pkg::*;
(
    // clock and store erase
    input wire logic ref_clk_i,
    input wire logic nv_rst_n_i,
    // programming
    input wire logic wr_cfg_i,
    input wire logic wr_ref_i,
    input wire logic [31:0] wdata_i,
    // decoded image
    output asr_mode_t mode_o,
    output logic [12:0] ref_angle_o,
    output logic ecc_det_o,
    output logic ecc_corr_o,
    output logic [11:0] cfg_raw_o,
    output logic [13:0] ref_raw_o
);

    logic [11:0] cfg_q;
    logic [13:0] ref_q;
    logic [NV_COPY_W-1:0] vote_w;
    logic [NV_COPY_W-1:0] diff_w;

    // storage survives power-up reset so the image is kept across power cycles
    always_ff @(posedge ref_clk_i) begin
        if (!nv_rst_n_i) begin
            cfg_q <= NV_CFG_RST;
            ref_q <= NV_REF_RST;
        end else begin
            if (wr_cfg_i) begin
                cfg_q <= wdata_i[11:0];
            end
            if (wr_ref_i) begin
                ref_q <= wdata_i[13:0];
            end
        end
    end

    // three copies: majority corrects any single bad copy
    for (genvar gi = 0; gi < NV_COPY_W; gi++) begin : g_vote
        wire a = cfg_q[gi];
        wire b = cfg_q[gi + NV_COPY_W];
        wire c = cfg_q[gi + 2 * NV_COPY_W];
        assign vote_w[gi] = (a & b) | (a & c) | (b & c);
        assign diff_w[gi] = (a ^ b) | (b ^ c);
    end

    // reference angle has even parity; an error is detected, not corrected
    assign mode_o = vote_w;
    assign ref_angle_o = ref_q[12:0];
    assign ecc_det_o = ^ref_q;
    assign ecc_corr_o = |diff_w;
    assign cfg_raw_o = cfg_q;
    assign ref_raw_o = ref_q;

endmodule // asr_nv_store

/* core/asr_die.sv */
// one sensor die: refresh timing, averaging, diagnostics, serial slave
// assumes the front end delivers raw samples on ref_clk_i; serial pins are asynchronous
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module asr_die
    import asr_pkg::*;
#(
    parameter bit SECONDARY_DIE = 1'b0
) (
    // clock, power-up reset and store erase
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic nv_rst_n_i,
    // local register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // front end and supply monitors
    input wire logic [12:0] raw_angle_i,
    input wire logic raw_valid_i,
    input wire logic field_low_i,
    input wire logic vcc_ok_i,
    input wire logic vcc_warn_i,
    input wire logic batt_lost_i,
    // serial port
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    // angle result
    output logic [12:0] angle_o,
    output logic angle_new_o
);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NPIN = 7;
    localparam logic [NPIN-1:0] PIN_IDLE = 7'h03;
    localparam logic [12:0] DIE_OFS = SECONDARY_DIE ? HALF_TURN : 13'h0000;
    wire [NPIN-1:0] pin_w;
    wire [NPIN-1:0] pin_s;

    assign pin_w = {batt_lost_i, vcc_warn_i, vcc_ok_i, field_low_i,
                    spi_mosi_i, spi_cs_n_i, spi_sclk_i};

    // two flops per pin; only the second one is looked at
    for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
        logic m_q;
        logic s_q;
        always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
                m_q <= PIN_IDLE[gi];
                s_q <= PIN_IDLE[gi];
            end else begin
                m_q <= pin_w[gi];
                s_q <= m_q;
            end
        end
        assign pin_s[gi] = s_q;
    end

    wire sclk_s = pin_s[0];
    wire cs_n_s = pin_s[1];
    wire mosi_s = pin_s[2];
    wire field_low_s = pin_s[3];
    wire vcc_ok_s = pin_s[4];
    wire vcc_low_s = pin_s[5];
    wire batt_lost_s = pin_s[6];

    // ------------------------------------------------------------
    // nonvolatile image
    // ------------------------------------------------------------
    asr_mode_t nv_mode;
    logic [12:0] ref_angle_w;
    logic nv_det_w;
    logic nv_corr_w;
    logic [11:0] cfg_raw_w;
    logic [13:0] ref_raw_w;
    wire wr_cfg_w = reg_we_i && (reg_addr_i == REG_NV_CFG);
    wire wr_ref_w = reg_we_i && (reg_addr_i == REG_NV_REF);

    asr_nv_store u_nv (
        .ref_clk_i(ref_clk_i),
        .nv_rst_n_i(nv_rst_n_i),
        .wr_cfg_i(wr_cfg_w),
        .wr_ref_i(wr_ref_w),
        .wdata_i(reg_wdata_i),
        .mode_o(nv_mode),
        .ref_angle_o(ref_angle_w),
        .ecc_det_o(nv_det_w),
        .ecc_corr_o(nv_corr_w),
        .cfg_raw_o(cfg_raw_w),
        .ref_raw_o(ref_raw_w)
    );

    // ------------------------------------------------------------
    // power-up and mode
    // ------------------------------------------------------------
    logic [11:0] por_cnt_q;
    logic ready_q;
    logic low_speed_q;
    logic ctrl_wr_w;
    logic [15:0] rx_q;
    wire por_done_w = !ready_q && (por_cnt_q == POR_LAST);
    wire active_w = ready_q && vcc_ok_s;

    // init runs for the power-on time after every reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            por_cnt_q <= 12'h000;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            por_cnt_q <= por_cnt_q + 12'h001;
            ready_q <= por_done_w;
        end
    end

    // mode default comes from the store; this die's port may then change it
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            low_speed_q <= 1'b0;
        end else if (por_done_w) begin
            low_speed_q <= nv_mode.low_speed;
        end else if (ctrl_wr_w) begin
            low_speed_q <= rx_q[CTRL_MODE_BIT];
        end
    end

    // ------------------------------------------------------------
    // raw sample capture and watchdog
    // ------------------------------------------------------------
    logic [12:0] raw_q;
    logic [8:0] wd_cnt_q;
    wire wd_fire_w = ready_q && (wd_cnt_q == WDOG_LAST);

    // watchdog trips when the front end stops delivering samples
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            raw_q <= 13'h0000;
            wd_cnt_q <= 9'h000;
        end else if (raw_valid_i) begin
            raw_q <= raw_angle_i + DIE_OFS;
            wd_cnt_q <= 9'h000;
        end else if (wd_cnt_q != WDOG_LAST) begin
            wd_cnt_q <= wd_cnt_q + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // refresh timing and averaging
    // ------------------------------------------------------------
    logic [7:0] base_cnt_q;
    logic [7:0] avg_cnt_q;
    logic [12:0] anchor_q;
    logic signed [19:0] acc_q;
    logic [12:0] angle_q;
    logic angle_new_q;
    wire base_tick_w = (base_cnt_q == BASE_LAST);
    wire [7:0] period_w = low_speed_q ? (8'h01 << nv_mode.averaging_exponent) : 8'h01;
    wire first_w = (avg_cnt_q == 8'h00);
    wire end_tick_w = base_tick_w && (avg_cnt_q >= period_w - 8'h01);
    wire [12:0] anchor_w = first_w ? raw_q : anchor_q;
    wire [12:0] diff_w = raw_q - anchor_w;
    wire signed [19:0] sum_w = (first_w ? 20'sh00000 : acc_q) + {{7{diff_w[12]}}, diff_w};
    wire [2:0] shamt_w = low_speed_q ? nv_mode.averaging_exponent : 3'h0;
    wire signed [19:0] mean_w = sum_w >>> shamt_w;
    wire [12:0] result_w = anchor_w + mean_w[12:0] - ref_angle_w;

    // deviations from the first sample are summed so the wrap at 0/360 does not bias the mean
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            base_cnt_q <= 8'h00;
            avg_cnt_q <= 8'h00;
            anchor_q <= 13'h0000;
            acc_q <= 20'sh00000;
        end else begin
            base_cnt_q <= base_tick_w ? 8'h00 : base_cnt_q + 8'h01;
            if (base_tick_w) begin
                avg_cnt_q <= end_tick_w ? 8'h00 : avg_cnt_q + 8'h01;
                anchor_q <= anchor_w;
                acc_q <= sum_w;
            end
        end
    end

    // result and its strobe; produced in either mode whatever the host does
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            angle_q <= 13'h0000;
            angle_new_q <= 1'b0;
        end else begin
            angle_new_q <= end_tick_w;
            if (end_tick_w) begin
                angle_q <= result_w;
            end
        end
    end

    // ------------------------------------------------------------
    // sticky diagnostic flags
    // ------------------------------------------------------------
    asr_flags_t flags_q;
    asr_flags_t set_w;
    asr_flags_t clr_w;
    logic wr_w;
    assign set_w = {batt_lost_s, nv_corr_w, nv_det_w, field_low_s, wd_fire_w};
    wire err_any_w = |flags_q;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= set_w | (flags_q & ~clr_w);
        end
    end

    // ------------------------------------------------------------
    // serial slave: idle-high clock, out on falling, in on rising
    // ------------------------------------------------------------
    logic sclk_prev_q;
    logic cs_prev_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] tx_q;
    logic in_frame_q;
    logic miso_q;
    logic oe_n_q;
    logic [6:0] rd_addr_q;
    wire sclk_rise_w = sclk_s && !sclk_prev_q;
    wire sclk_fall_w = !sclk_s && sclk_prev_q;
    wire cs_fall_w = !cs_n_s && cs_prev_q;
    wire cs_rise_w = cs_n_s && !cs_prev_q;
    wire cmd_go_w = cs_rise_w && in_frame_q && (bit_cnt_q == FRAME_BITS) && active_w;
    wire [6:0] cmd_addr_w = rx_q[14:8];
    assign wr_w = cmd_go_w && rx_q[CMD_WRITE_BIT];
    assign ctrl_wr_w = wr_w && (cmd_addr_w == SPI_ADDR_CTRL);
    assign clr_w = (wr_w && (cmd_addr_w == SPI_ADDR_FLAGS)) ? rx_q[4:0] : FLAGS_RST;

    // answer words; the angle word carries the low supply flag
    wire [15:0] ang_word_w = {err_any_w, vcc_low_s, 1'b0, angle_q};
    wire [15:0] flag_word_w = {10'h000, vcc_low_s, flags_q};
    wire [15:0] ctrl_word_w = {13'h0000, low_speed_q, 2'b00};
    wire [15:0] resp_w = (rd_addr_q == SPI_ADDR_ANGLE) ? ang_word_w :
                         (rd_addr_q == SPI_ADDR_FLAGS) ? flag_word_w :
                         (rd_addr_q == SPI_ADDR_CTRL) ? ctrl_word_w : 16'h0000;

    // frame engine; frames that start while not active are never driven or decoded
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
            bit_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            in_frame_q <= 1'b0;
            miso_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
            if (cs_fall_w && active_w) begin
                tx_q <= resp_w;
                bit_cnt_q <= 5'h00;
                in_frame_q <= 1'b1;
                oe_n_q <= 1'b0;
            end else if (cs_rise_w) begin
                in_frame_q <= 1'b0;
                oe_n_q <= 1'b1;
            end else if (in_frame_q && sclk_fall_w) begin
                miso_q <= tx_q[15];
                tx_q <= {tx_q[14:0], 1'b0};
            end else if (in_frame_q && sclk_rise_w) begin
                rx_q <= {rx_q[14:0], mosi_s};
                bit_cnt_q <= (bit_cnt_q == 5'h1F) ? bit_cnt_q : bit_cnt_q + 5'h01;
            end
        end
    end

    // read address of the last read command picks the next frame's answer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_addr_q <= SPI_ADDR_ANGLE;
        end else if (cmd_go_w && !rx_q[CMD_WRITE_BIT]) begin
            rd_addr_q <= cmd_addr_w;
        end
    end

    // ------------------------------------------------------------
    // local register read-back
    // ------------------------------------------------------------
    logic [31:0] rdata_q;
    wire [31:0] status_w = {21'h000000, nv_mode.averaging_exponent, ready_q,
                            low_speed_q, vcc_low_s, flags_q};
    wire [31:0] rsel_w = (reg_addr_i == REG_NV_CFG) ? {20'h00000, cfg_raw_w} :
                         (reg_addr_i == REG_NV_REF) ? {18'h00000, ref_raw_w} :
                         (reg_addr_i == REG_STATUS) ? status_w :
                         (reg_addr_i == REG_ANGLE) ? {19'h00000, angle_q} : 32'h00000000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= reg_re_i ? rsel_w : 32'h00000000;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign spi_miso_o = miso_q;
    assign spi_miso_oe_n_o = oe_n_q;
    assign angle_o = angle_q;
    assign angle_new_o = angle_new_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [11:0] ast_cyc_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ast_cyc_q <= 12'h000;
        end else if (ast_cyc_q != 12'hFFF) begin
            ast_cyc_q <= ast_cyc_q + 12'h001;
        end
    end

    sequence s_read_cmd;
        cmd_go_w && !rx_q[CMD_WRITE_BIT];
    endsequence
    sequence s_frame_open;
        cs_fall_w && active_w;
    endsequence

    AST_HS_PERIOD:
        assert property ((angle_new_o && !low_speed_q) |-> ##250 (angle_new_o || low_speed_q))
        else $error("high-speed refresh not 250 cycles");
    AST_HS_ANGLE:
        assert property ((end_tick_w && !low_speed_q)
                         |=> angle_o == $past(raw_q) - $past(ref_angle_w))
        else $error("angle is not raw minus reference");
    AST_POR_TIME:
        assert property ($rose(ready_q) |-> ast_cyc_q == 12'hBB8)
        else $error("power-on time wrong");
    AST_MODE_LOAD:
        assert property ($rose(ready_q) |-> low_speed_q == $past(nv_mode.low_speed))
        else $error("mode not loaded from store");
    AST_QUIET_INIT:
        assert property (!ready_q |-> spi_miso_oe_n_o)
        else $error("driving during init");
    AST_ADDR_SEL:
        assert property (s_read_cmd |=> rd_addr_q == $past(cmd_addr_w))
        else $error("read address not taken");
    AST_TX_LOAD:
        assert property (s_frame_open |=> tx_q == $past(resp_w) && !spi_miso_oe_n_o)
        else $error("answer not loaded at frame start");
    AST_MSB_FIRST:
        assert property ((in_frame_q && sclk_fall_w && !cs_rise_w)
                         |=> ##1 spi_miso_o == $past(tx_q[15], 2))
        else $error("bit order wrong");
    AST_VLOW_MSG:
        assert property ((rd_addr_q == SPI_ADDR_ANGLE) |-> resp_w[14] == vcc_low_s)
        else $error("low supply flag missing");
    AST_SET_WINS:
        assert property ((|set_w) |=> ((flags_q & $past(set_w)) == $past(set_w)))
        else $error("flag event lost");
    AST_WDOG:
        assert property ((ready_q && !raw_valid_i && wd_cnt_q == WDOG_LAST - 9'h001)
                         |-> ##2 flags_q.internal_error_flag)
        else $error("watchdog did not trip");
    AST_DIE_OFS:
        assert property (raw_valid_i |=> raw_q == $past(raw_angle_i) + DIE_OFS)
        else $error("die offset wrong");

endmodule // asr_die

/* sim/asr_host_model.sv */
// host side spi master model that polls one die
// assumes mode 3 frames of 16 bits and an sclk period of about 800 ns
`timescale 1ns/1ps
module asr_host_model (
    // serial pins
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    input wire logic spi_miso_oe_n_i,
    // received word
    output logic [15:0] rx_o,
    output logic done_o
);
    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    logic last_q = 1'b0;
    logic wire_w;

    // a released miso line shows the inverse of its last level
    assign wire_w = spi_miso_oe_n_i ? ~last_q : spi_miso_i;

    // sclk and cs idle high between frames
    initial begin
        spi_sclk_o = 1'b1;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        rx_o = 16'h0000;
        done_o = 1'b0;
    end

    // sample late in the high phase: the pin path delays miso by a few ref cycles
    task automatic xfer(input logic [15:0] cmd);
        #37 spi_cs_n_o = 1'b0;
        #400;
        // 800 ns sclk period: 400 ns low, 400 ns high
        for (int i = 15; i >= 0; i--) begin
            spi_sclk_o = 1'b0;
            spi_mosi_o = cmd[i];
            #400 spi_sclk_o = 1'b1;
            #390 rx_o[i] = wire_w;
            last_q = wire_w;
            #10;
        end
        #400 spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        done_o = 1'b1;
        #100 done_o = 1'b0;
        #900;
    endtask
endmodule // asr_host_model

/* sim/tb_top.sv */
// self-checking bench for one primary die polled by the host spi model
// assumes a 10 MHz ref clock and the hand-over register and frame layout
`timescale 1ns/1ps
module tb_top;
    import asr_pkg::*;
    // ------------------------------------------------------------
    // signals and scoreboard
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, nv_rst_n_i = 1'b0, reg_we_i = 1'b0;
    logic reg_re_i = 1'b0, raw_valid_i = 1'b0, field_low_i = 1'b0, vcc_ok_i = 1'b1;
    logic vcc_warn_i = 1'b0, batt_lost_i = 1'b0, rd_d = 1'b0, raw_hold = 1'b0;
    logic sclk, cs_n, mosi, miso, oe_n, done, angle_new_o;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [12:0] raw_angle_i = 13'h0, angle_o, ref_ang, exp_ang;
    logic [15:0] rx, gap = 16'h0, lfsr_q = 16'h1A6E; // seed 6766
    logic [31:0] exp_reg_q[$], exp_ang_q[$], exp_spi_q[$];
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    asr_die #(.SECONDARY_DIE(1'b0)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .nv_rst_n_i(nv_rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .raw_angle_i(raw_angle_i),
        .raw_valid_i(raw_valid_i), .field_low_i(field_low_i), .vcc_ok_i(vcc_ok_i),
        .vcc_warn_i(vcc_warn_i), .batt_lost_i(batt_lost_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n),
        .angle_o(angle_o), .angle_new_o(angle_new_o));
    asr_host_model u_host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
        .spi_miso_i(miso), .spi_miso_oe_n_i(oe_n), .rx_o(rx), .done_o(done));

    // 100 ns clock
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        exp_reg_q.push_back(e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_re_i <= 1'b0;
    endtask
    task automatic spi(input logic [15:0] cmd, input bit chk, input logic [15:0] e);
        if (chk) exp_spi_q.push_back({16'h0000, e});
        u_host.xfer(cmd);
        // realign so the next stimulus lands on a clock edge
        @(posedge ref_clk_i);
    endtask
    // skip two refreshes so the result holds only the new raw input
    task automatic ang_chk(input logic [15:0] g);
        exp_ang = raw_angle_i - ref_ang;
        repeat (2) @(posedge angle_new_o);
        exp_ang_q.push_back({g, 3'h0, exp_ang});
        wait (exp_ang_q.size() == 0);
    endtask

    // ------------------------------------------------------------
    // monitor, raw feed and timeout
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        raw_valid_i <= rst_n_i && !raw_hold;
        cycles <= cycles + 1;
        rd_d <= reg_re_i;
        gap <= angle_new_o ? 16'h0001 : gap + 16'h0001;
        if (rd_d) check("reg_rdata", reg_rdata_o, exp_reg_q.pop_front());
        if (angle_new_o && exp_ang_q.size() > 0) begin
            check("angle_gap", {gap, 3'h0, angle_o}, exp_ang_q.pop_front());
        end
        if (done && exp_spi_q.size() > 0) check("spi_rx", {16'h0, rx}, exp_spi_q.pop_front());
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        nv_rst_n_i <= 1'b1;
        reg_rd(REG_NV_CFG, 32'h0);
        reg_rd(4'h1, 32'h0);
        reg_wr(REG_NV_CFG, 32'h0991);
        reg_rd(REG_NV_CFG, 32'h0991);
        lfsr_q = lfsr(lfsr_q);
        ref_ang = lfsr_q[12:0];
        reg_wr(REG_NV_REF, {18'h0, ^ref_ang, ref_ang});
        lfsr_q = lfsr(lfsr_q);
        raw_angle_i <= lfsr_q[12:0];
        repeat (3000) @(posedge ref_clk_i);
        reg_rd(REG_STATUS, 32'h01C8);
        ang_chk(16'h01F4);
        vcc_warn_i <= 1'b1;
        field_low_i <= 1'b1;
        batt_lost_i <= 1'b1;
        spi(16'h8200, 1'b0, 16'h0);
        spi(16'h0200, 1'b0, 16'h0);
        spi(16'h0000, 1'b1, 16'h0000);
        ang_chk(16'h00FA);
        reg_rd(REG_ANGLE, {19'h0, exp_ang});
        spi(16'h0100, 1'b1, {3'b110, exp_ang});
        spi(16'h0100, 1'b1, 16'h003A);
        field_low_i <= 1'b0;
        batt_lost_i <= 1'b0;
        spi(16'h811F, 1'b1, 16'h003A);
        spi(16'h0100, 1'b1, 16'h0028);
        vcc_ok_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        spi(16'h8204, 1'b0, 16'h0);
        vcc_ok_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        spi(16'h0200, 1'b0, 16'h0);
        spi(16'h8204, 1'b1, 16'h0000);
        spi(16'h0000, 1'b1, 16'h0004);
        // starve the front end so the watchdog trips
        raw_hold <= 1'b1;
        repeat (520) @(posedge ref_clk_i);
        reg_rd(REG_STATUS, 32'h01E9);
        repeat (2) @(posedge ref_clk_i);
        close_out();
    end
endmodule // tb_top
